// ---- hdl/rrs_pkg.sv ----
// shared constants for the return, rotate and sleep execute block
package rrs_pkg;
	localparam int INSTR_WIDTH = 12;
	localparam int DATA_WIDTH = 8;
	localparam int ADDR_WIDTH = 5;
	localparam int PC_WIDTH = 9;
	localparam int WDT_WIDTH = 8;
	localparam int PRESCALE_WIDTH = 8;
	// opcode patterns
	localparam logic [3:0] RETLIT_TOP = 4'h8;
	localparam logic [5:0] ROT_LEFT_TOP = 6'h0D;
	localparam logic [5:0] ROT_RIGHT_TOP = 6'h0C;
	localparam logic [11:0] SLEEP_CODE = 12'h003;
	// field positions
	localparam int TOP4_MSB = 11;
	localparam int TOP4_LSB = 8;
	localparam int TOP6_MSB = 11;
	localparam int TOP6_LSB = 6;
	localparam int DEST_BIT = 5;
	// cycle counts
	localparam int RETLIT_CYCLES = 2;
	// reset values
	localparam logic [7:0] WDT_CLEARED = 8'h00;
	localparam logic [7:0] PRESCALE_CLEARED = 8'h00;
	localparam logic [7:0] DATA_ZERO = 8'h00;
	localparam logic [8:0] PC_ZERO = 9'h000;
	// file register start pattern, xored with the register index
	localparam logic [7:0] FILE_SEED = 8'hA5;
	// register bus offsets (byte addresses)
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_INSTR = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam logic [3:0] OFS_ACCUM = 4'hC;
	// status and control field positions
	localparam int ST_CARRY = 0;
	localparam int ST_TIMEOUT = 1;
	localparam int ST_POWERDOWN = 2;
	localparam int ST_PINWAKE = 3;
	localparam int ST_SLEEPING = 4;
	localparam int ST_BUSY = 5;
	localparam int CTL_WAKE = 0;
	localparam int CTL_LOAD_TOS = 1;
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_RET2 = 2'b01,
		ST_SLEEP = 2'b10
	} phase_type;
endpackage

// ---- hdl/return_rotate_sleep_exec.sv ----
// execute logic for return-with-literal, rotate through carry and sleep
//What this block does
//RQ1: the return-with-literal op loads its literal into the accumulator, pops the stack top into the PC and takes 2 cycles.
//RQ2: the left-rotate op rotates the file register left through carry, changing only carry in status.
//RQ3: the right-rotate op rotates the file register right through carry, changing only carry in status.
//RQ4: a rotate result goes to the accumulator when the destination bit is 0 and to the file register when 1.
//RQ5: the rotate file operand is a 5-bit field selecting registers 0 to 31.
//RQ6: the sleep op enters low power and stops the oscillator.
//RQ7: sleep sets the timeout flag.
//RQ8: sleep clears the power-down flag.
//RQ9: sleep resets the watchdog counter to 00h and clears its prescaler.
//RQ10: sleep sets the pin-change wake flag.
//RQ11: the bit shifted out becomes the new carry and the old carry fills the vacated bit.
//RQ12: rotate and sleep finish in one instruction cycle and take one program word.
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module return_rotate_sleep_exec
#(
	parameter int REG_COUNT = 32
)
(
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	output logic OSC_RUN,
	output logic [8:0] PC
);
	// ****************************************
	// parameter check
	// ****************************************
	if (REG_COUNT != (1 << rrs_pkg::ADDR_WIDTH))
	begin : g_bad_count
		$error("REG_COUNT must equal the file operand range");
	end

	typedef logic [rrs_pkg::DATA_WIDTH-1:0] byte_type;

	typedef struct packed
	{
		rrs_pkg::phase_type phase;
		logic ack;
		logic [31:0] rdata;
		byte_type accum;
		logic carry;
		logic timeout_flag;
		logic powerdown_flag;
		logic pin_change_wake_flag;
		logic [rrs_pkg::WDT_WIDTH-1:0] watchdog_counter;
		logic [rrs_pkg::PRESCALE_WIDTH-1:0] prescale;
		logic [rrs_pkg::PC_WIDTH-1:0] pc;
		logic [rrs_pkg::PC_WIDTH-1:0] stack_top;
		logic osc_run;
		logic [rrs_pkg::INSTR_WIDTH-1:0] instr;
	} state_type;

	state_type s;
	state_type next_s;
	byte_type file_mem [REG_COUNT];
	logic file_we;
	logic [rrs_pkg::ADDR_WIDTH-1:0] file_addr;
	byte_type file_wdata;

	// ****************************************
	// decode and execute
	// ****************************************
	logic [rrs_pkg::INSTR_WIDTH-1:0] op;
	logic is_ret;
	logic is_rlf;
	logic is_rrf;
	logic is_sleep;
	byte_type src;
	byte_type rot;
	logic rot_carry;
	logic wr_hit;
	logic rd_hit;

	always_comb
	begin
		op = AVS_WRITEDATA[rrs_pkg::INSTR_WIDTH-1:0];
		is_ret = op[rrs_pkg::TOP4_MSB:rrs_pkg::TOP4_LSB] == rrs_pkg::RETLIT_TOP;
		is_rlf = op[rrs_pkg::TOP6_MSB:rrs_pkg::TOP6_LSB] == rrs_pkg::ROT_LEFT_TOP;
		is_rrf = op[rrs_pkg::TOP6_MSB:rrs_pkg::TOP6_LSB] == rrs_pkg::ROT_RIGHT_TOP;
		is_sleep = op == rrs_pkg::SLEEP_CODE;
		file_addr = op[rrs_pkg::ADDR_WIDTH-1:0]; //RQ5
		src = file_mem[file_addr];
		if (is_rlf)
		begin
			rot = {src[rrs_pkg::DATA_WIDTH-2:0], s.carry}; //RQ2 RQ11
			rot_carry = src[rrs_pkg::DATA_WIDTH-1]; //RQ11
		end
		else
		begin
			rot = {s.carry, src[rrs_pkg::DATA_WIDTH-1:1]}; //RQ3 RQ11
			rot_carry = src[0]; //RQ11
		end
		wr_hit = AVS_WRITE && !s.ack;
		rd_hit = AVS_READ && !s.ack;
		file_we = 1'b0;
		file_wdata = rot;
		next_s = s;
		next_s.ack = (AVS_READ || AVS_WRITE) && !s.ack;
		if (s.phase == rrs_pkg::ST_RET2)
		begin
			next_s.phase = rrs_pkg::ST_IDLE; //RQ1
		end
		if (wr_hit && AVS_ADDRESS == rrs_pkg::OFS_CONTROL)
		begin
			if (AVS_WRITEDATA[rrs_pkg::CTL_WAKE] && s.phase == rrs_pkg::ST_SLEEP)
			begin
				next_s.phase = rrs_pkg::ST_IDLE;
				next_s.osc_run = 1'b1;
			end
			if (AVS_WRITEDATA[rrs_pkg::CTL_LOAD_TOS])
			begin
				next_s.stack_top = AVS_WRITEDATA[16 +: rrs_pkg::PC_WIDTH];
			end
		end
		if (wr_hit && AVS_ADDRESS == rrs_pkg::OFS_ACCUM)
		begin
			next_s.accum = AVS_WRITEDATA[rrs_pkg::DATA_WIDTH-1:0];
		end
		if (wr_hit && AVS_ADDRESS == rrs_pkg::OFS_INSTR && s.phase == rrs_pkg::ST_IDLE)
		begin
			next_s.instr = op;
			if (is_ret)
			begin
				next_s.accum = op[rrs_pkg::DATA_WIDTH-1:0]; //RQ1
				next_s.pc = s.stack_top; //RQ1
				next_s.phase = rrs_pkg::ST_RET2; //RQ1
			end
			else if (is_rlf || is_rrf)
			begin
				next_s.carry = rot_carry; //RQ2 RQ3
				next_s.pc = s.pc + 1'b1; //RQ12
				if (op[rrs_pkg::DEST_BIT])
				begin
					file_we = 1'b1; //RQ4
				end
				else
				begin
					next_s.accum = rot; //RQ4
				end
			end
			else if (is_sleep)
			begin
				next_s.timeout_flag = 1'b1; //RQ7
				next_s.powerdown_flag = 1'b0; //RQ8
				next_s.watchdog_counter = rrs_pkg::WDT_CLEARED; //RQ9
				next_s.prescale = rrs_pkg::PRESCALE_CLEARED; //RQ9
				next_s.pin_change_wake_flag = 1'b1; //RQ10
				next_s.osc_run = 1'b0; //RQ6
				next_s.phase = rrs_pkg::ST_SLEEP; //RQ6
				next_s.pc = s.pc + 1'b1; //RQ12
			end
			else
			begin
				next_s.pc = s.pc + 1'b1;
			end
		end
		next_s.rdata = s.rdata;
		if (rd_hit)
		begin
			case (AVS_ADDRESS)
				rrs_pkg::OFS_CONTROL: next_s.rdata = {7'h00, s.stack_top, 16'h0000};
				rrs_pkg::OFS_INSTR: next_s.rdata = {20'h0_0000, s.instr[11:0]};
				rrs_pkg::OFS_STATUS: next_s.rdata = {26'h000_0000, s.phase != rrs_pkg::ST_IDLE,
					s.phase == rrs_pkg::ST_SLEEP, s.pin_change_wake_flag, s.powerdown_flag,
					s.timeout_flag, s.carry};
				rrs_pkg::OFS_ACCUM: next_s.rdata = {24'h00_0000, s.accum};
				default: next_s.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// state registers
	// ****************************************
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			s <= '{phase: rrs_pkg::ST_IDLE, ack: 1'b0, rdata: 32'h0000_0000, accum: rrs_pkg::DATA_ZERO,
				carry: 1'b0, timeout_flag: 1'b1, powerdown_flag: 1'b1, pin_change_wake_flag: 1'b0,
				watchdog_counter: rrs_pkg::WDT_CLEARED, prescale: rrs_pkg::PRESCALE_CLEARED,
				pc: rrs_pkg::PC_ZERO, stack_top: rrs_pkg::PC_ZERO, osc_run: 1'b1, instr: 12'h000};
		end
		else
		begin
			s <= next_s;
		end
	end

	// file registers start from a known pattern so rotates never see unknowns
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			for (int i = 0; i < REG_COUNT; i++)
			begin
				file_mem[i] <= byte_type'(i) ^ rrs_pkg::FILE_SEED;
			end
		end
		else if (file_we)
		begin
			file_mem[file_addr] <= file_wdata; //RQ4
		end
	end

	// watchdog counter and prescale are never advanced; only reset and sleep clear them
	// (both held in the state struct, with no next value path that counts them)
	assign AVS_READDATA = s.rdata;
	assign AVS_WAITREQUEST = !s.ack;
	assign OSC_RUN = s.osc_run;
	assign PC = s.pc;
endmodule // return_rotate_sleep_exec

// ---- test/rrs_checker.sv ----
// port assertions for the execute block
`timescale 1ns/1ns
module rrs_checker
(
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic OSC_RUN,
	input wire logic [8:0] PC
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);
	sequence s_op;
		AVS_WRITE && AVS_WAITREQUEST && AVS_ADDRESS == 4'h4 && OSC_RUN;
	endsequence
	sequence s_rot;
		s_op ##0 AVS_WRITEDATA[11:7] == 5'h06;
	endsequence
	sequence s_sleep;
		s_op ##0 AVS_WRITEDATA[11:0] == 12'h003;
	endsequence
	chk_wait_one: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("no answer");
	chk_wait_back: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("answer too long");
	chk_rot_step: assert property (s_rot |=> PC == $past(PC) + 9'h001)
		else $error("rotate pc step");
	chk_sleep_stop: assert property (s_sleep |=> !OSC_RUN && PC == $past(PC) + 9'h001)
		else $error("sleep not entered");
	chk_stay_asleep: assert property (!OSC_RUN && !(AVS_WRITE && AVS_ADDRESS == 4'h0) |=> !OSC_RUN && $stable(PC))
		else $error("woke without cause");
	chk_wake_up: assert property (!OSC_RUN && AVS_WRITE && AVS_WAITREQUEST && AVS_ADDRESS == 4'h0 && AVS_WRITEDATA[0]
		|=> OSC_RUN) else $error("no wake");
	chk_unmapped_zero: assert property (AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS[1:0] != 2'h0
		|=> AVS_READDATA == 32'h0000_0000) else $error("unmapped data");
	chk_osc_cause: assert property ($fell(OSC_RUN) |-> $past(AVS_WRITE && AVS_WRITEDATA[11:0] == 12'h003))
		else $error("stopped without sleep");
endmodule // rrs_checker
bind return_rotate_sleep_exec rrs_checker u_chk (.CLK(CLK), .ARST_N(ARST_N), .AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .OSC_RUN(OSC_RUN), .PC(PC));

// ---- test/prog_word.sv ----
// program memory model handing out instruction words
`timescale 1ns/1ns
module prog_word
(
	input wire logic [1:0] kind,
	input wire logic [7:0] arg,
	output logic [11:0] word
);
	always_comb
	begin
		case (kind)
			2'd0: word = {4'h8, arg};
			2'd1: word = {6'h0D, arg[5:0]};
			2'd2: word = {6'h0C, arg[5:0]};
			default: word = 12'h003;
		endcase
	end
endmodule // prog_word

// ---- test/return_rotate_sleep_exec_tb.sv ----
// self-checking bench for the execute block
`timescale 1ns/1ns
module return_rotate_sleep_exec_tb;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata, got;
	logic [7:0] mem_m [32];
	logic [7:0] acc_m;
	logic dir, d;
	logic waitreq, osc, c;
	logic [8:0] pc, pc_m, st;
	logic [1:0] kind = 2'd0;
	logic [7:0] arg = 8'h00;
	logic [7:0] f;
	logic [4:0] fr;
	logic [11:0] word;
	integer seed = 46774;
	integer err_total = 0;
	integer checks_done = 0;
	always #50 clk = ~clk;
	// expected {carry out, result} of a rotate through carry
	function automatic logic [8:0] rot_exp(input logic left, input logic [7:0] v, input logic cin);
		if (left)
			return {v, cin};
		return {v[0], cin, v[7:1]};
	endfunction
	return_rotate_sleep_exec u_dut (.CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .OSC_RUN(osc), .PC(pc));
	prog_word u_mem (.kind(kind), .arg(arg), .word(word));
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk);
			if (!waitreq)
				break;
		end
		if (n == 20)
		begin
			err_total++;
			summarize();
		end
		got = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	// fetch a word, execute it, follow the program counter
	task automatic run(input logic [1:0] k, input logic [7:0] a);
		kind <= k;
		arg <= a;
		@(posedge clk);
		bus(1'b1, rrs_pkg::OFS_INSTR, {20'h0_0000, word});
		pc_m = (k == 2'd0) ? st : pc_m + 9'h001;
		check("pc", pc, pc_m);
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		pc_m = 9'h000;
		c = 1'b0;
		bus(1'b0, rrs_pkg::OFS_STATUS, 32'h0000_0000);
		check("status", got, 32'h0000_0006);
		bus(1'b0, 4'h1, 32'h0000_0000);
		check("unmapped", got, 32'h0000_0000);
		$display("reset test done");
		for (int j = 0; j < 32; j++)
		begin
			mem_m[j] = 8'(j) ^ rrs_pkg::FILE_SEED;
		end
		acc_m = 8'h00;
		for (int i = 0; i < 12; i++)
		begin
			fr = (i == 0) ? 5'h1F : ((i == 1) ? 5'h00 : 5'($random(seed)));
			dir = 1'($random(seed));
			d = (i < 2) ? 1'b1 : 1'($random(seed));
			run(dir ? 2'd1 : 2'd2, {2'b00, d, fr});
			{c, f} = rot_exp(dir, mem_m[fr], c);
			if (d)
				mem_m[fr] = f;
			else
				acc_m = f;
			bus(1'b0, rrs_pkg::OFS_ACCUM, 32'h0000_0000);
			check("accum", got, {24'h00_0000, acc_m});
			bus(1'b0, rrs_pkg::OFS_STATUS, 32'h0000_0000);
			check("flags", got[3:1], 3'b011);
			check("carry", got, {26'h000_0000, 5'b00011, c});
			run(dir ? 2'd2 : 2'd1, {3'b000, fr});
			{c, acc_m} = rot_exp(!dir, mem_m[fr], c);
			bus(1'b0, rrs_pkg::OFS_ACCUM, 32'h0000_0000);
			check("rotate", got, {24'h00_0000, acc_m});
			bus(1'b0, rrs_pkg::OFS_STATUS, 32'h0000_0000);
			check("carry back", got, {26'h000_0000, 5'b00011, c});
		end
		$display("rotate test done");
		repeat (3)
		begin
			st = 9'($random(seed));
			f = 8'($random(seed));
			bus(1'b1, rrs_pkg::OFS_CONTROL, {7'h00, st, 16'h0002});
			run(2'd0, f);
			bus(1'b0, rrs_pkg::OFS_ACCUM, 32'h0000_0000);
			check("literal", got, {24'h00_0000, f});
		end
		$display("return test done");
		run(2'd3, 8'h00);
		check("osc", osc, 1'b0);
		bus(1'b0, rrs_pkg::OFS_STATUS, 32'h0000_0000);
		check("sleep flags", got, {26'h000_0000, 5'b11101, c});
		bus(1'b1, rrs_pkg::OFS_INSTR, 32'h0000_0340);
		check("asleep pc", pc, pc_m);
		bus(1'b1, rrs_pkg::OFS_CONTROL, 32'h0000_0001);
		check("wake", osc, 1'b1);
		$display("sleep test done");
		arst_n <= 1'b0;
		@(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		bus(1'b0, rrs_pkg::OFS_STATUS, 32'h0000_0000);
		check("reset status", got, 32'h0000_0006);
		check("reset pc", pc, 32'h0000_0000);
		check("reset osc", osc, 1'b1);
		$display("second reset test done");
		summarize();
	end
endmodule // return_rotate_sleep_exec_tb
